// File: smfio_top.sv
// Multifunction digital I/O block: four ports, trigger path, output sources.
//
// How it works
// R1: Four ports, each set by software to input or output.
// R2: Software inverts each port's polarity in both directions.
// R3: Port one as trigger starts a measurement directly in the sequencer.
// R4: The controller holds a trigger pulse for at least 50 us.
// R5: A valid trigger edge starts a measurement within 10 us.
// R6: The controller uses ports two to four only for slow levels.
// R7: Each output port is routed to one selectable internal source.
// R8: One source is a software-written bit driven onto the output.
// R9: Ready-for-trigger is high whenever the next trigger can be accepted.
// R10: A trigger while not ready raises overrun and starts nothing.
// R11: Measurement-in-progress spans first exposure to end of data transfer.
// R12: Image-sequence-active spans first image to last image transmitted.
// R13: Critical fault on hardware failure or excessive internal temperature.
// R14: Outputs are active low, pulling the line toward I/O ground.
// R15: State light blinks orange/green during init, then steady green.
// R16: No measurements above 63 C, shutdown above 65, warning above 60.
// R17: Every port input is synchronised in two stages before any logic.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "smfio_params.svh"

module smfio_top
  import smfio_pkg::*;
#(
  parameter int NPORT     = `SMFIO_NPORT,
  parameter int BLINK_CYC = `SMFIO_BLINK_NS / `SMFIO_CLK_NS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Port pins
  input  wire logic [NPORT-1:0]  port_in,
  output logic      [NPORT-1:0]  port_out,
  output logic      [NPORT-1:0]  port_oe,
  // Sensor state
  input  wire smfio_sens_s       sens,
  output logic                   meas_start,
  // Indicators and alarms
  output logic                   led_green,
  output logic                   led_orange,
  output logic                   temp_warn,
  output logic                   shutdown_req,
  output logic                   irq
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  localparam int TRIG_LAT_CYC = `SMFIO_TRIG_MAX_LAT_NS / `SMFIO_CLK_NS;
  localparam int PATH_CYC     = 4;
  if (NPORT != `SMFIO_NPORT)
  begin : g_chk_port
    $error("smfio_top serves exactly four ports");
  end
  if (BLINK_CYC < 2 || BLINK_CYC >= (1 << `SMFIO_BLINK_W))
  begin : g_chk_blink
    $error("smfio_top blink count out of range");
  end
  if (PATH_CYC > TRIG_LAT_CYC)
  begin : g_chk_lat
    $error("smfio_top trigger path too slow");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  smfio_state_s            st_q;
  smfio_state_s            st_d;
  logic [NPORT-1:0]        in_lvl;
  logic [7:0]              src_lvl;
  logic                    over_warn;
  logic                    over_block;
  logic                    over_shdn;
  logic                    ready_now;
  logic                    trig_edge;
  logic [`SMFIO_NIRQ-1:0]  ev;
  logic [`SMFIO_NIRQ-1:0]  w1c;
  logic [NPORT-1:0]        drive;

  // --------------------------------------------------------------------------
  // Input synchroniser
  // --------------------------------------------------------------------------
  // R17: two-stage sync
  // R2: input polarity
  smfio_insync #(
    .W       (NPORT)
  ) u_insync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_raw (port_in),
    .inv     (st_q.pol),
    .lvl     (in_lvl)
  );

  // --------------------------------------------------------------------------
  // Sources and conditions
  // --------------------------------------------------------------------------
  // R16: temperature thresholds
  assign over_warn  = sens.temp_c > `SMFIO_TEMP_WARN_C;
  assign over_block = sens.temp_c > `SMFIO_TEMP_BLOCK_C;
  assign over_shdn  = sens.temp_c > `SMFIO_TEMP_SHDN_C;

  // R9: ready includes heat and init
  assign ready_now = sens.seq_ready & sens.init_done & ~over_block
                     & ~sens.hw_fault;

  // R3: trigger path from port one
  // The edge is taken from the synchronised level, so a pulse shorter than
  // one clock may be lost; the controller must honour the minimum width.
  assign trig_edge = st_q.trig_en & ~st_q.dir[0] & in_lvl[0]
                     & ~st_q.in_prev[0];

  // R7: selectable source list
  always_comb
  begin
    src_lvl                    = 8'h00;
    // R8: software bit
    src_lvl[SMFIO_SRC_SW]      = st_q.sw_out;
    src_lvl[SMFIO_SRC_READY]   = ready_now;
    src_lvl[SMFIO_SRC_OVERRUN] = st_q.ovr;
    src_lvl[SMFIO_SRC_MEAS]    = st_q.meas_act;
    src_lvl[SMFIO_SRC_SEQ]     = st_q.seq_act;
    // R13: fault or overheating
    src_lvl[SMFIO_SRC_FAULT]   = sens.hw_fault | over_shdn;
  end

  // R1: per-port output driving
  for (genvar g = 0; g < NPORT; g++)
  begin : g_drive
    logic [`SMFIO_SEL_W-1:0] code;
    assign code     = st_q.sel[g*`SMFIO_SEL_STRIDE +: `SMFIO_SEL_W];
    // R2: output polarity
    assign drive[g] = st_q.dir[g] & (src_lvl[code] ^ st_q.pol[g]);
  end

  // --------------------------------------------------------------------------
  // Events and write-one-to-clear mask
  // --------------------------------------------------------------------------
  always_comb
  begin
    ev                       = '0;
    ev[`SMFIO_IRQ_TRIG_BIT]  = trig_edge & ready_now;
    ev[`SMFIO_IRQ_OVR_BIT]   = trig_edge & ~ready_now;
    ev[`SMFIO_IRQ_FAULT_BIT] = src_lvl[SMFIO_SRC_FAULT] & ~st_q.fault_prev;
    ev[`SMFIO_IRQ_WARN_BIT]  = over_warn & ~st_q.warn_prev;
    ev[`SMFIO_IRQ_IN_LSB +: NPORT] = ~st_q.dir & (in_lvl ^ st_q.in_prev);
    w1c = '0;
    if (reg_wr && reg_addr == `SMFIO_ADDR_IRQ_STAT)
    begin
      w1c = reg_wdata[`SMFIO_NIRQ-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_d            = st_q;
    st_d.in_prev    = in_lvl;
    st_d.fault_prev = src_lvl[SMFIO_SRC_FAULT];
    st_d.warn_prev  = over_warn;
    st_d.rdata      = 32'h0000_0000;

    // Register writes.
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SMFIO_ADDR_CTRL:
        begin
          st_d.dir     = reg_wdata[`SMFIO_CTRL_DIR_LSB +: NPORT];
          st_d.trig_en = reg_wdata[`SMFIO_CTRL_TRIG_EN_BIT];
          st_d.sw_out  = reg_wdata[`SMFIO_CTRL_SWOUT_BIT];
        end
        `SMFIO_ADDR_POL:
        begin
          st_d.pol = reg_wdata[NPORT-1:0];
        end
        `SMFIO_ADDR_SEL:
        begin
          st_d.sel = reg_wdata[15:0];
        end
        `SMFIO_ADDR_IRQ_MASK:
        begin
          st_d.irq_mask = reg_wdata[`SMFIO_NIRQ-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // Sticky status: a new event beats a clear in the same cycle.
    st_d.irq_stat = (st_q.irq_stat & ~w1c) | ev;
    st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

    // R3: start the measurement
    // R5: start within a few cycles
    st_d.meas_start = trig_edge & ready_now;
    // R10: overrun held until next start
    if (trig_edge && !ready_now)
    begin
      st_d.ovr = 1'b1;
    end
    else if (trig_edge)
    begin
      st_d.ovr = 1'b0;
    end

    // R11: measurement window
    if (sens.exposure_start)
    begin
      st_d.meas_act = 1'b1;
    end
    else if (sens.gige_done)
    begin
      st_d.meas_act = 1'b0;
    end

    // R12: image sequence window
    if (sens.img_first)
    begin
      st_d.seq_act = 1'b1;
    end
    else if (sens.img_last_tx)
    begin
      st_d.seq_act = 1'b0;
    end

    // R14: active low open-drain drive
    st_d.pout = '0;
    st_d.poe  = drive;

    // R16: warning and shutdown
    st_d.warn     = over_warn;
    st_d.shutdown = over_shdn;

    // R15: state light
    unique case (st_q.led)
      SMFIO_LED_INIT_G, SMFIO_LED_INIT_O:
      begin
        if (sens.init_done)
        begin
          st_d.led       = SMFIO_LED_RUN;
          st_d.blink_cnt = '0;
        end
        else if (st_q.blink_cnt == `SMFIO_BLINK_W'(BLINK_CYC - 1))
        begin
          st_d.blink_cnt = '0;
          st_d.led       = (st_q.led == SMFIO_LED_INIT_G) ?
                           SMFIO_LED_INIT_O : SMFIO_LED_INIT_G;
        end
        else
        begin
          st_d.blink_cnt = st_q.blink_cnt + `SMFIO_BLINK_W'(1);
        end
      end
      SMFIO_LED_RUN:
      begin
        if (!sens.init_done)
        begin
          st_d.led = SMFIO_LED_INIT_G;
        end
      end
      default:
      begin
        st_d.led = SMFIO_LED_INIT_G;
      end
    endcase
    st_d.led_green  = (st_d.led != SMFIO_LED_INIT_O);
    st_d.led_orange = (st_d.led == SMFIO_LED_INIT_O);

    // Register reads, answered in the next cycle only.
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SMFIO_ADDR_CTRL:
        begin
          st_d.rdata[`SMFIO_CTRL_DIR_LSB +: NPORT] = st_q.dir;
          st_d.rdata[`SMFIO_CTRL_TRIG_EN_BIT]      = st_q.trig_en;
          st_d.rdata[`SMFIO_CTRL_SWOUT_BIT]        = st_q.sw_out;
        end
        `SMFIO_ADDR_POL:
        begin
          st_d.rdata[NPORT-1:0] = st_q.pol;
        end
        `SMFIO_ADDR_SEL:
        begin
          st_d.rdata[15:0] = st_q.sel;
        end
        `SMFIO_ADDR_STAT:
        begin
          st_d.rdata[`SMFIO_STAT_LVL_LSB +: NPORT] = in_lvl;
          st_d.rdata[`SMFIO_STAT_SRC_LSB +: 8]     = src_lvl;
          st_d.rdata[`SMFIO_STAT_WARN_BIT]         = over_warn;
          st_d.rdata[`SMFIO_STAT_BLOCK_BIT]        = over_block;
          st_d.rdata[`SMFIO_STAT_SHDN_BIT]         = over_shdn;
          st_d.rdata[`SMFIO_STAT_INIT_BIT]         = sens.init_done;
        end
        `SMFIO_ADDR_IRQ_STAT:
        begin
          st_d.rdata[`SMFIO_NIRQ-1:0] = st_q.irq_stat;
        end
        `SMFIO_ADDR_IRQ_MASK:
        begin
          st_d.rdata[`SMFIO_NIRQ-1:0] = st_q.irq_mask;
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q           <= '0;
      st_q.dir       <= `SMFIO_RST_DIR;
      st_q.pol       <= `SMFIO_RST_POL;
      st_q.sel       <= `SMFIO_RST_SEL;
      st_q.irq_mask  <= `SMFIO_RST_MASK;
      st_q.led       <= SMFIO_LED_INIT_G;
      st_q.led_green <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata    = st_q.rdata;
  assign port_out     = st_q.pout;
  assign port_oe      = st_q.poe;
  assign meas_start   = st_q.meas_start;
  assign led_green    = st_q.led_green;
  assign led_orange   = st_q.led_orange;
  assign temp_warn    = st_q.warn;
  assign shutdown_req = st_q.shutdown;
  assign irq          = st_q.irq;

endmodule

`default_nettype wire

// File: smfio_params.svh
// Offsets, field positions, reset values and timing in nanoseconds of the multifunction I/O block.
`ifndef SMFIO_PARAMS_SVH
`define SMFIO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define SMFIO_NPORT            4
`define SMFIO_SEL_STRIDE       4
`define SMFIO_SEL_W            3
`define SMFIO_NIRQ             8
`define SMFIO_BLINK_W          25

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SMFIO_ADDR_CTRL        8'h00
`define SMFIO_ADDR_POL         8'h04
`define SMFIO_ADDR_SEL         8'h08
`define SMFIO_ADDR_STAT        8'h0C
`define SMFIO_ADDR_IRQ_STAT    8'h10
`define SMFIO_ADDR_IRQ_MASK    8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SMFIO_CTRL_DIR_LSB     0
`define SMFIO_CTRL_TRIG_EN_BIT 4
`define SMFIO_CTRL_SWOUT_BIT   8
`define SMFIO_STAT_LVL_LSB     0
`define SMFIO_STAT_SRC_LSB     8
`define SMFIO_STAT_WARN_BIT    16
`define SMFIO_STAT_BLOCK_BIT   17
`define SMFIO_STAT_SHDN_BIT    18
`define SMFIO_STAT_INIT_BIT    19
`define SMFIO_IRQ_TRIG_BIT     0
`define SMFIO_IRQ_OVR_BIT      1
`define SMFIO_IRQ_FAULT_BIT    2
`define SMFIO_IRQ_WARN_BIT     3
`define SMFIO_IRQ_IN_LSB       4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMFIO_RST_DIR          4'h0
`define SMFIO_RST_POL          4'h0
`define SMFIO_RST_SEL          16'h0000
`define SMFIO_RST_MASK         8'h00

// ----------------------------------------------------------------------------
// Temperature limits in degrees Celsius and timing
// ----------------------------------------------------------------------------
`define SMFIO_TEMP_WARN_C      8'h3C
`define SMFIO_TEMP_BLOCK_C     8'h3F
`define SMFIO_TEMP_SHDN_C      8'h41
`define SMFIO_CLK_NS           10
`define SMFIO_BLINK_NS         250000000
`define SMFIO_TRIG_MIN_NS      50000
`define SMFIO_TRIG_MAX_LAT_NS  10000

`endif

// File: smfio_pkg.sv
// Types shared by the multifunction I/O block.
`include "smfio_params.svh"

package smfio_pkg;

  // Output source codes, three bits per port.
  typedef enum logic [2:0] {
    SMFIO_SRC_SW      = 3'h0,
    SMFIO_SRC_READY   = 3'h1,
    SMFIO_SRC_OVERRUN = 3'h2,
    SMFIO_SRC_MEAS    = 3'h3,
    SMFIO_SRC_SEQ     = 3'h4,
    SMFIO_SRC_FAULT   = 3'h5
  } smfio_src_e;

  typedef enum logic [1:0] {
    SMFIO_LED_INIT_G = 2'h0,
    SMFIO_LED_INIT_O = 2'h1,
    SMFIO_LED_RUN    = 2'h2
  } smfio_led_e;

  // Internal sensor state signals presented to the block.
  typedef struct packed {
    logic       seq_ready;
    logic       exposure_start;
    logic       gige_done;
    logic       img_first;
    logic       img_last_tx;
    logic       hw_fault;
    logic       init_done;
    logic [7:0] temp_c;
  } smfio_sens_s;

  typedef struct packed {
    logic [`SMFIO_NPORT-1:0]   dir;
    logic                      trig_en;
    logic                      sw_out;
    logic [`SMFIO_NPORT-1:0]   pol;
    logic [15:0]               sel;
    logic [`SMFIO_NIRQ-1:0]    irq_stat;
    logic [`SMFIO_NIRQ-1:0]    irq_mask;
    logic [`SMFIO_NPORT-1:0]   in_prev;
    logic                      ovr;
    logic                      meas_act;
    logic                      seq_act;
    logic                      fault_prev;
    logic                      warn_prev;
    logic                      meas_start;
    logic [`SMFIO_NPORT-1:0]   pout;
    logic [`SMFIO_NPORT-1:0]   poe;
    logic [31:0]               rdata;
    logic                      irq;
    smfio_led_e                led;
    logic [`SMFIO_BLINK_W-1:0] blink_cnt;
    logic                      led_green;
    logic                      led_orange;
    logic                      warn;
    logic                      shutdown;
  } smfio_state_s;

endpackage

// File: smfio_insync.sv
// Two-stage input synchroniser with per-bit polarity for the port inputs.
`timescale 1ns/100ps
`default_nettype none

module smfio_insync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Raw pins and polarity
  input  wire logic [W-1:0] pin_raw,
  input  wire logic [W-1:0] inv,
  // Synchronised level
  output logic      [W-1:0] lvl
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smfio_sync_s;

  smfio_sync_s st_q;
  smfio_sync_s st_d;

  if (W < 1)
  begin : g_chk
    $error("smfio_insync needs at least one bit");
  end

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_raw;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Polarity is applied only after the second stage.
  for (genvar g = 0; g < W; g++)
  begin : g_pol
    assign lvl[g] = st_q.s2[g] ^ inv[g];
  end

endmodule

`default_nettype wire

// File: smfio_props.sv
// Concurrent checks on the ports of the multifunction I/O block.
`timescale 1ns/100ps
`default_nettype none

module smfio_props
  import smfio_pkg::*;
#(
  parameter int NPORT = 4
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Register port
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Pins and sensor
  input wire logic [NPORT-1:0]  port_out,
  input wire smfio_sens_s       sens,
  input wire logic              meas_start,
  // Indicators
  input wire logic              led_green,
  input wire logic              led_orange,
  input wire logic              temp_warn,
  input wire logic              shutdown_req,
  input wire logic              irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic rdy_ok;
  assign rdy_ok = sens.seq_ready & sens.init_done & ~sens.hw_fault;

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  chk_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("measurement start longer than one cycle");
  chk_start_ready: assert property (meas_start |-> $past(rdy_ok))
    else $error("measurement started while not ready");
  chk_start_cool: assert property (
    meas_start |-> $past(sens.temp_c) <= 8'h3F)
    else $error("measurement started while too hot");
  chk_warn_level: assert property (
    !$past(rst) |-> temp_warn == ($past(sens.temp_c) > 8'h3C))
    else $error("warning flag does not follow temperature");
  chk_shdn_level: assert property (
    !$past(rst) |-> shutdown_req == ($past(sens.temp_c) > 8'h41))
    else $error("shutdown flag does not follow temperature");
  chk_out_low: assert property (port_out == {NPORT{1'b0}})
    else $error("output pin value not low");
  chk_led_steady: assert property (
    $past(sens.init_done) |-> led_green && !led_orange)
    else $error("state light not steady green after init");
  chk_led_excl: assert property (!(led_green && led_orange))
    else $error("both light colours on");

  cov_start: cover property (meas_start);
  cov_irq: cover property (irq);
  cov_orange: cover property (led_orange);
  cov_shdn: cover property (shutdown_req);
endmodule

bind smfio_top smfio_props #(.NPORT(NPORT)) u_props (
  .clk_sys      (clk_sys),
  .rst          (rst),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .port_out     (port_out),
  .sens         (sens),
  .meas_start   (meas_start),
  .led_green    (led_green),
  .led_orange   (led_orange),
  .temp_warn    (temp_warn),
  .shutdown_req (shutdown_req),
  .irq          (irq)
);
`default_nettype wire

// File: smfio_ctrl_model.sv
// Behavioural external controller driving the four port lines.
`timescale 1ns/100ps
`default_nettype none

module smfio_ctrl_model #(
  parameter int TRIG_HOLD = 5000
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Pin side
  input  wire logic [3:0] port_oe,
  output logic      [3:0] port_in,
  // Bench commands
  input  wire logic [3:0] lvl,
  input  wire logic       trig_req,
  output logic            trig_busy
);
  int cnt_q;

  // hold trigger pulse
  // The count is reset so that the trigger line never starts unknown.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 0;
    end
    else if (trig_req)
    begin
      cnt_q <= TRIG_HOLD;
    end
    else if (cnt_q != 0)
    begin
      cnt_q <= cnt_q - 1;
    end
  end

  assign trig_busy = (cnt_q != 0);
  // slow levels only
  // A line that the block pulls low reads low whatever is driven here.
  assign port_in = ~port_oe & (lvl | {3'b000, trig_busy});
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench of the multifunction I/O block.
`timescale 1ns/100ps
`default_nettype none
`include "smfio_params.svh"

module tb;
  import smfio_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0]  port_in;
  logic [3:0]  port_out;
  logic [3:0]  port_oe;
  smfio_sens_s sens;
  logic        meas_start;
  logic        led_green;
  logic        led_orange;
  logic        temp_warn;
  logic        shutdown_req;
  logic        irq;
  logic [3:0]  lvl;
  logic        trig_req;
  logic        trig_busy;
  logic [31:0] rv;
  logic        seen_or;
  int          n_mismatch;
  int          samples_checked;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [5:0]  exp_src [3] = '{6'b000011, 6'b011011, 6'b111001};

  smfio_top #(.BLINK_CYC(4)) dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .sens(sens),
    .meas_start(meas_start), .led_green(led_green),
    .led_orange(led_orange), .temp_warn(temp_warn),
    .shutdown_req(shutdown_req), .irq(irq));
  smfio_ctrl_model u_ctrl (.clk_sys(clk_sys), .rst(rst), .port_oe(port_oe),
    .port_in(port_in), .lvl(lvl), .trig_req(trig_req),
    .trig_busy(trig_busy));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pls(input logic s);
    @(posedge clk_sys);
    sens.exposure_start <= s;
    sens.img_first      <= s;
    sens.gige_done      <= !s;
    sens.img_last_tx    <= !s;
    @(posedge clk_sys);
    sens.exposure_start <= 1'b0;
    sens.img_first      <= 1'b0;
    sens.gige_done      <= 1'b0;
    sens.img_last_tx    <= 1'b0;
  endtask
  // The count window is far inside both the pulse and the start limit.
  task automatic trig(input int n_exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    trig_req <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 1'b0;
    repeat (40)
    begin
      @(posedge clk_sys);
      #1;
      n += int'(meas_start === 1'b1);
    end
    chk(32'(n), 32'(n_exp));
    while (trig_busy === 1'b1) @(posedge clk_sys);
    cyc(5);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lvl = 4'h0;
    trig_req = 1'b0;
    seen_or = 1'b0;
    sens = '0;
    sens.seq_ready = 1'b1;
    sens.temp_c = 8'h19;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    wr(8'h18, 32'hFFFFFFFF);
    wr(`SMFIO_ADDR_STAT, 32'hFFFFFFFF);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(rv, 32'h0);
    end
    for (int i = 0; i < 20; i++)
    begin
      cyc(1);
      seen_or |= led_orange;
    end
    chk(32'(seen_or), 32'h1);
    sens.init_done <= 1'b1;
    cyc(3);
    chk(32'({led_green, led_orange}), 32'h2);
    wr(`SMFIO_ADDR_CTRL, 32'h10F);
    cyc(3);
    chk(32'(port_oe), 32'hF);
    wr(`SMFIO_ADDR_POL, 32'hF);
    cyc(3);
    chk(32'(port_oe), 32'h0);
    wr(`SMFIO_ADDR_POL, 32'h0);
    for (int ph = 0; ph < 3; ph++)
    begin
      if (ph == 1)
        pls(1'b1);
      if (ph == 2)
        sens.hw_fault <= 1'b1;
      cyc(3);
      for (int c = 0; c < 6; c++)
      begin
        wr(`SMFIO_ADDR_SEL, 32'h1111 * c);
        cyc(3);
        chk(32'(port_oe), {28'h0, {4{exp_src[ph][c]}}});
        rd(`SMFIO_ADDR_STAT);
        chk(32'(rv[13:8]), 32'(exp_src[ph]));
      end
    end
    pls(1'b0);
    sens.hw_fault <= 1'b0;
    wr(`SMFIO_ADDR_CTRL, 32'h0);
    wr(`SMFIO_ADDR_IRQ_STAT, 32'hFF);
    wr(`SMFIO_ADDR_IRQ_MASK, 32'hF0);
    lvl <= 4'hA;
    cyc(6);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[3:0]), 32'hA);
    rd(`SMFIO_ADDR_IRQ_STAT);
    chk(32'(rv[7:4]), 32'hA);
    chk(32'(irq), 32'h1);
    wr(`SMFIO_ADDR_POL, 32'hF);
    cyc(6);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[3:0]), 32'h5);
    lvl <= 4'h0;
    wr(`SMFIO_ADDR_POL, 32'h0);
    wr(`SMFIO_ADDR_CTRL, 32'h10);
    cyc(6);
    wr(`SMFIO_ADDR_IRQ_STAT, 32'hFF);
    wr(`SMFIO_ADDR_IRQ_MASK, 32'h03);
    cyc(2);
    chk(32'(irq), 32'h0);
    trig(1);
    rd(`SMFIO_ADDR_IRQ_STAT);
    chk(32'(rv[1:0]), 32'h1);
    chk(32'(irq), 32'h1);
    sens.seq_ready <= 1'b0;
    trig(0);
    rd(`SMFIO_ADDR_IRQ_STAT);
    chk(32'(rv[1:0]), 32'h3);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[10:8]), 32'h4);
    sens.seq_ready <= 1'b1;
    sens.temp_c <= 8'h40;
    cyc(3);
    trig(0);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[19:16]), 32'hB);
    sens.temp_c <= 8'h42;
    cyc(3);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[19:13]), 32'h79);
    chk(32'({temp_warn, shutdown_req}), 32'h3);
    sens.temp_c <= 8'h3D;
    cyc(3);
    rd(`SMFIO_ADDR_STAT);
    chk(32'(rv[19:16]), 32'h9);
    chk(32'({temp_warn, shutdown_req}), 32'h2);
    end_sim();
  end
endmodule
`default_nettype wire
